// ### bridge_input_control.sv
// Purpose: map PWM pins and register fields to four gate command pairs
// Assumes: dead time is inserted by a later gate sequencing block
// Notes: registers on classic Wishbone, one-cycle ack
`timescale 1ns/10ps
`default_nettype none
module bridge_input_control (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic STRAP_VARIANT,
  input wire logic [1:0] STRAP_MODE,
  input wire logic [3:0] PWM_IN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic [3:0] HIGH_GATE_OUT,
  output logic [3:0] LOW_GATE_OUT
);

  bridge_pkg::wb_req_t req;
  logic [3:0] pin_sync;
  logic [2:0] strap_sync;
  logic strap_var_r, strap_var_nxt;
  logic [1:0] strap_mode_r, strap_mode_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [7:0] state_r, state_nxt;
  logic [7:0] map_r, map_nxt;
  logic [7:0] pwmcfg_r, pwmcfg_nxt;
  logic [11:0] hctrl_r, hctrl_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [3:0] high_r, high_nxt;
  logic [3:0] low_r, low_nxt;
  logic [1:0] eff_mode;
  logic wr_en;
  logic rd_en;

  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I,
                 adr: WB_ADR_I, sel: WB_SEL_I, dat: WB_DAT_I};

  // pins pass two flops before decode
  input_sync #(.WIDTH(4)) u_pin_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .pin_in(PWM_IN),
    .sync_out(pin_sync)
  );

  input_sync #(.WIDTH(3)) u_strap_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .pin_in({STRAP_VARIANT, STRAP_MODE}),
    .sync_out(strap_sync)
  );

  // merge a written byte lane into a register byte
  function automatic logic [7:0] lane(input logic [7:0] old,
                                      input logic [7:0] dat,
                                      input logic en);
    lane = en ? dat : old;
  endfunction

  // half-bridge gates from its state and pwm config
  function automatic bridge_pkg::gate_pair_t half_gate(
      input logic [1:0] st, input logic pwm,
      input logic side, input logic fwtype);
    bridge_pkg::gate_pair_t g;
    g = '{high_gate: 1'b0, low_gate: 1'b0};
    case (st)
      bridge_pkg::HB_FLOAT: g = '{high_gate: 1'b0, low_gate: 1'b0};
      bridge_pkg::HB_LOW: g = '{high_gate: 1'b0, low_gate: 1'b1};
      bridge_pkg::HB_HIGH: g = '{high_gate: 1'b1, low_gate: 1'b0};
      bridge_pkg::HB_PWM: begin
        if (!side) begin
          g.high_gate = pwm;
          g.low_gate = fwtype ? 1'b0 : ~pwm;
        end else begin
          g.low_gate = pwm;
          g.high_gate = fwtype ? 1'b0 : ~pwm;
        end
      end
      default: g = '{high_gate: 1'b0, low_gate: 1'b0};
    endcase
    half_gate = g;
  endfunction

  // hbridge direction/enable decode, returns {gh1,gl1,gh2,gl2}
  function automatic logic [3:0] phen_gate(input logic en, input logic ph,
                                           input logic fw, input logic flt);
    logic [3:0] g;
    g = 4'h0;
    if (flt) begin
      g = 4'h0;
    end else if (!en) begin
      g = fw ? 4'hA : 4'h5;
    end else begin
      g = ph ? 4'h9 : 4'h6;
    end
    phen_gate = g;
  endfunction

  // strap levels taken from the synchroniser every cycle
  always_comb begin
    strap_var_nxt = strap_sync[2];
    strap_mode_nxt = strap_sync[1:0];
  end

  // capture register for the synced strap levels
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_var_r <= 1'b0;
      strap_mode_r <= 2'h0;
    end else begin
      strap_var_r <= strap_var_nxt;
      strap_mode_r <= strap_mode_nxt;
    end
  end

  // mode from straps or register
  assign eff_mode = strap_var_r ? strap_mode_r : mode_r;

  // register bus slave: one-cycle ack, unmapped reads zero
  // write lands on the edge where the master samples ack high
  assign wr_en = req.cyc & req.stb & req.we & ack_r;
  // read data registered on the taking edge so it stands with ack
  assign rd_en = req.cyc & req.stb & ~req.we & ~ack_r;

  always_comb begin
    mode_nxt = mode_r;
    state_nxt = state_r;
    map_nxt = map_r;
    pwmcfg_nxt = pwmcfg_r;
    hctrl_nxt = hctrl_r;
    ack_nxt = req.cyc & req.stb & ~ack_r;
    rdat_nxt = 32'h0000_0000;
    if (wr_en) begin
      case (req.adr)
        bridge_pkg::MODE_OFS: begin
          if (req.sel[0]) begin
            mode_nxt = req.dat[1:0];
          end
        end
        bridge_pkg::STATE_OFS: state_nxt = lane(state_r, req.dat[7:0],
                                                req.sel[0]);
        bridge_pkg::MAP_OFS: map_nxt = lane(map_r, req.dat[7:0],
                                            req.sel[0]);
        bridge_pkg::PWMCFG_OFS: pwmcfg_nxt = lane(pwmcfg_r, req.dat[7:0],
                                                  req.sel[0]);
        bridge_pkg::HCTRL_OFS: begin
          hctrl_nxt[7:0] = lane(hctrl_r[7:0], req.dat[7:0], req.sel[0]);
          if (req.sel[1]) begin
            hctrl_nxt[11:8] = req.dat[11:8];
          end
        end
        default: mode_nxt = mode_r;
      endcase
    end
    // reads return the addressed field, zero-extended
    if (rd_en) begin
      case (req.adr)
        bridge_pkg::MODE_OFS: rdat_nxt = {30'h0, mode_r};
        bridge_pkg::STATE_OFS: rdat_nxt = {24'h0, state_r};
        bridge_pkg::MAP_OFS: rdat_nxt = {24'h0, map_r};
        bridge_pkg::PWMCFG_OFS: rdat_nxt = {24'h0, pwmcfg_r};
        bridge_pkg::HCTRL_OFS: rdat_nxt = {20'h0, hctrl_r};
        bridge_pkg::STATUS_OFS: rdat_nxt = {17'h0, strap_var_r,
                                            eff_mode, pin_sync,
                                            high_r, low_r};
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // register file and bus answer flops
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_r <= bridge_pkg::MODE_RST;
      state_r <= bridge_pkg::STATE_RST;
      map_r <= bridge_pkg::MAP_RST;
      pwmcfg_r <= bridge_pkg::PWMCFG_RST;
      hctrl_r <= bridge_pkg::HCTRL_RST;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      mode_r <= mode_nxt;
      state_r <= state_nxt;
      map_r <= map_nxt;
      pwmcfg_r <= pwmcfg_nxt;
      hctrl_r <= hctrl_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // bus outputs straight from flops
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdat_r;

  // gate decode per mode
  always_comb begin
    bridge_pkg::gate_pair_t gp;
    logic [1:0] sel;
    logic [1:0] st;
    logic side;
    logic fwt;
    logic [3:0] hg;
    logic en;
    logic ph;
    logic fws;
    gp = '{high_gate: 1'b0, low_gate: 1'b0};
    sel = 2'h0;
    st = 2'h0;
    side = 1'b0;
    fwt = 1'b0;
    hg = 4'h0;
    en = 1'b0;
    ph = 1'b0;
    fws = 1'b0;
    high_nxt = 4'h0;
    low_nxt = 4'h0;
    case (eff_mode)
      bridge_pkg::MODE_HALF: begin
        for (int i = 0; i < 4; i++) begin
          if (strap_var_r) begin
            sel = 2'(i);
            st = bridge_pkg::HB_PWM;
            side = 1'b0;
            fwt = 1'b0;
          end else begin
            sel = map_r[2*i +: 2];
            st = state_r[2*i +: 2];
            side = pwmcfg_r[bridge_pkg::DRV_SIDE_POS + i];
            fwt = pwmcfg_r[bridge_pkg::FW_TYPE_POS + i];
          end
          gp = half_gate(st, pin_sync[sel], side, fwt);
          high_nxt[i] = gp.high_gate;
          low_nxt[i] = gp.low_gate;
        end
      end
      bridge_pkg::MODE_PHEN: begin
        for (int b = 0; b < 2; b++) begin
          en = hctrl_r[bridge_pkg::EN_SRC_POS + b] ?
               hctrl_r[bridge_pkg::EN_VAL_POS + b] : pin_sync[2*b];
          ph = hctrl_r[bridge_pkg::PH_SRC_POS + b] ?
               hctrl_r[bridge_pkg::PH_VAL_POS + b] : pin_sync[2*b+1];
          fws = strap_var_r ? 1'b0 :
                hctrl_r[bridge_pkg::FW_SIDE_POS + b];
          hg = phen_gate(en, ph, fws, hctrl_r[bridge_pkg::FLOAT_POS + b]);
          high_nxt[2*b] = hg[3];
          low_nxt[2*b] = hg[2];
          high_nxt[2*b+1] = hg[1];
          low_nxt[2*b+1] = hg[0];
        end
      end
      // dual pwm and split modes leave every gate off
      default: begin
        high_nxt = 4'h0;
        low_nxt = 4'h0;
      end
    endcase
  end

  // gate command flops
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      high_r <= 4'h0;
      low_r <= 4'h0;
    end else begin
      high_r <= high_nxt;
      low_r <= low_nxt;
    end
  end

  // gate outputs straight from flops
  assign HIGH_GATE_OUT = high_r;
  assign LOW_GATE_OUT = low_r;

endmodule // bridge_input_control
`default_nettype wire

// ### bridge_input_control_bench.sv
// Purpose: self-checking bench for bridge_input_control
// Assumes: host model drives pins, bench drives the bus
// Notes: strap cases first, while registers hold reset values
`timescale 1ns/10ps
`default_nettype none
module bridge_input_control_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic strap_var = 1'b1;
  logic [1:0] strap_mode = 2'h0;
  logic [3:0] lvl = 4'h0;
  logic [3:0] pwm;
  bridge_pkg::wb_req_t req = '0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic [3:0] hg;
  logic [3:0] lg;
  int fails = 0;
  int tests_run = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  host_pwm_model u_host (.clk(clk), .level(lvl), .pwm(pwm));
  bridge_input_control u_dut (.CLK(clk), .RESET_N(reset_n),
    .STRAP_VARIANT(strap_var), .STRAP_MODE(strap_mode), .PWM_IN(pwm),
    .WB_CYC_I(req.cyc), .WB_STB_I(req.stb), .WB_WE_I(req.we),
    .WB_ADR_I(req.adr), .WB_SEL_I(req.sel), .WB_DAT_I(req.dat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .HIGH_GATE_OUT(hg),
    .LOW_GATE_OUT(lg));
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    for (i = 0; i < 20 && ack !== 1'b1; i++)
      @(posedge clk);
    if (ack !== 1'b1) begin
      fails++;
      tally_and_finish();
    end else begin
      q = rdat;
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
    end
  endtask
  // let pins pass the synchroniser, then compare gates
  task automatic gates(input logic [3:0] h, input logic [3:0] l);
    logic [3:0] hs;
    logic [3:0] ls;
    repeat (5) @(posedge clk);
    @(negedge clk);
    hs = hg;
    ls = lg;
    @(posedge clk);
    check({24'h0, hs, ls}, {24'h0, h, l});
  endtask
  // {high pair, low pair} for one enable/direction pair
  function automatic logic [3:0] phen(input logic [1:0] p);
    if (!p[0]) return 4'b0011;
    return p[1] ? 4'b0110 : 4'b1001;
  endfunction
  initial begin
    logic [3:0] a;
    logic [3:0] b;
    int k;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    lvl <= 4'hA;
    gates(4'hA, 4'h5);
    lvl <= 4'h6;
    gates(4'h6, 4'h9);
    strap_mode <= 2'h1;
    for (k = 0; k < 16; k++) begin
      lvl <= k[3:0];
      a = phen(k[1:0]);
      b = phen(k[3:2]);
      gates({b[3:2], a[3:2]}, {b[1:0], a[1:0]});
    end
    strap_mode <= 2'h2;
    gates(4'h0, 4'h0);
    strap_mode <= 2'h3;
    gates(4'h0, 4'h0);
    // registers in charge from here on
    strap_var <= 1'b0;
    gates(4'h0, 4'h0);
    wb(1'b0, bridge_pkg::MAP_OFS, 32'h0);
    check(q, {24'h0, bridge_pkg::MAP_RST});
    wb(1'b1, 8'h18, 32'hFFFF_FFFF);
    wb(1'b0, 8'h18, 32'h0);
    check(q, 32'h0);
    wb(1'b1, bridge_pkg::STATE_OFS, 32'hE4);
    lvl <= 4'h8;
    gates(4'hC, 4'h2);
    lvl <= 4'h0;
    gates(4'h4, 4'hA);
    // every select code feeds all four bridges
    for (k = 0; k < 4; k++) begin
      wb(1'b1, bridge_pkg::STATE_OFS, 32'h0);
      wb(1'b1, bridge_pkg::MAP_OFS, {24'h0, {4{k[1:0]}}});
      wb(1'b1, bridge_pkg::PWMCFG_OFS, 32'h35);
      wb(1'b1, bridge_pkg::STATE_OFS, 32'hFF);
      lvl <= 4'h1 << k;
      gates(4'hA, 4'h5);
      lvl <= ~(4'h1 << k);
      gates(4'h4, 4'h8);
    end
    wb(1'b1, bridge_pkg::MODE_OFS, 32'h1);
    lvl <= 4'h3;
    wb(1'b1, bridge_pkg::HCTRL_OFS, 32'h215);
    gates(4'hE, 4'h1);
    wb(1'b1, bridge_pkg::HCTRL_OFS, 32'h615);
    gates(4'hC, 4'h0);
    wb(1'b0, bridge_pkg::HCTRL_OFS, 32'h0);
    check(q, 32'h615);
    wb(1'b0, bridge_pkg::STATUS_OFS, 32'h0);
    check(q, 32'h13C0);
    tally_and_finish();
  end
endmodule // bridge_input_control_bench
`default_nettype wire

// ### bridge_input_control_sva.sv
// Purpose: gate output checks for bridge_input_control
// Assumes: strap pins stay put for several cycles in each case
// Notes: pin to gate latency is three edges
`timescale 1ns/10ps
`default_nettype none
module bridge_input_control_chk (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic STRAP_VARIANT,
  input wire logic [1:0] STRAP_MODE,
  input wire logic [3:0] PWM_IN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic [3:0] HIGH_GATE_OUT,
  input wire logic [3:0] LOW_GATE_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // strap held in one mode long enough to be decoded
  sequence s_half; (STRAP_VARIANT && STRAP_MODE == 2'h0)[*6]; endsequence
  sequence s_phen; (STRAP_VARIANT && STRAP_MODE == 2'h1)[*6]; endsequence
  sequence s_dual; (STRAP_VARIANT && STRAP_MODE == 2'h2)[*6]; endsequence
  property p_no_overlap;
    (HIGH_GATE_OUT & LOW_GATE_OUT) == 4'h0;
  endproperty
  property p_half_high;
    s_half |-> HIGH_GATE_OUT == $past(PWM_IN, 3);
  endproperty
  property p_half_low;
    s_half |-> LOW_GATE_OUT == ~$past(PWM_IN, 3);
  endproperty
  property p_phen_off;
    s_phen ##0 ($past(PWM_IN, 3) & 4'h1) == 4'h0
      |-> HIGH_GATE_OUT[1:0] == 2'h0 && LOW_GATE_OUT[1:0] == 2'h3;
  endproperty
  property p_phen_fwd;
    s_phen ##0 ($past(PWM_IN, 3) & 4'h3) == 4'h3
      |-> HIGH_GATE_OUT[1:0] == 2'h1 && LOW_GATE_OUT[1:0] == 2'h2;
  endproperty
  property p_phen_rev;
    s_phen ##0 ($past(PWM_IN, 3) & 4'h3) == 4'h1
      |-> HIGH_GATE_OUT[1:0] == 2'h2 && LOW_GATE_OUT[1:0] == 2'h1;
  endproperty
  property p_phen_pair2;
    s_phen ##0 ($past(PWM_IN, 3) & 4'hC) == 4'hC
      |-> HIGH_GATE_OUT[3:2] == 2'h1 && LOW_GATE_OUT[3:2] == 2'h2;
  endproperty
  property p_dual_off;
    s_dual |-> HIGH_GATE_OUT == 4'h0 && LOW_GATE_OUT == 4'h0;
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both gates of a bridge on");
  a_half_high: assert property (p_half_high)
    else $error("strap high gate not following pin");
  a_half_low: assert property (p_half_low)
    else $error("strap low gate not complement");
  a_phen_off: assert property (p_phen_off)
    else $error("enable low not low-side freewheel");
  a_phen_fwd: assert property (p_phen_fwd)
    else $error("forward drive wrong");
  a_phen_rev: assert property (p_phen_rev)
    else $error("reverse drive wrong");
  a_phen_pair2: assert property (p_phen_pair2)
    else $error("second pair forward wrong");
  a_dual_off: assert property (p_dual_off)
    else $error("dual pwm mode gates not low");
endmodule // bridge_input_control_chk
bind bridge_input_control bridge_input_control_chk u_chk (
  .CLK(CLK),
  .RESET_N(RESET_N),
  .STRAP_VARIANT(STRAP_VARIANT),
  .STRAP_MODE(STRAP_MODE),
  .PWM_IN(PWM_IN),
  .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O),
  .HIGH_GATE_OUT(HIGH_GATE_OUT),
  .LOW_GATE_OUT(LOW_GATE_OUT)
);
`default_nettype wire

// ### bridge_pkg.sv
// Purpose: shared constants and types for the bridge input control logic
// Assumes: four half-bridges, four PWM inputs, 32-bit Wishbone registers
// Notes: register offsets are byte addresses of aligned words
package bridge_pkg;

  // register byte offsets
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] STATE_OFS = 8'h04;
  localparam logic [7:0] MAP_OFS = 8'h08;
  localparam logic [7:0] PWMCFG_OFS = 8'h0C;
  localparam logic [7:0] HCTRL_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;

  // reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] STATE_RST = 8'h00;
  localparam logic [7:0] MAP_RST = 8'hE4;
  localparam logic [7:0] PWMCFG_RST = 8'h00;
  localparam logic [11:0] HCTRL_RST = 12'h000;

  // field positions in the hbridge control register
  localparam int EN_SRC_POS = 0;
  localparam int PH_SRC_POS = 2;
  localparam int EN_VAL_POS = 4;
  localparam int PH_VAL_POS = 6;
  localparam int FW_SIDE_POS = 8;
  localparam int FLOAT_POS = 10;
  // field positions in the pwm config register
  localparam int DRV_SIDE_POS = 0;
  localparam int FW_TYPE_POS = 4;

  typedef enum logic [1:0] {
    MODE_HALF = 2'b00,
    MODE_PHEN = 2'b01,
    MODE_DPWM = 2'b10,
    MODE_SPLIT = 2'b11
  } bridge_mode_t;

  typedef enum logic [1:0] {
    HB_FLOAT = 2'b00,
    HB_LOW = 2'b01,
    HB_HIGH = 2'b10,
    HB_PWM = 2'b11
  } hb_state_t;

  // one gate command pair
  typedef struct packed {
    logic high_gate;
    logic low_gate;
  } gate_pair_t;

  // wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage

// ### host_pwm_model.sv
// Purpose: host side driver of the pwm and direction pins
// Assumes: levels requested by the bench, one per pin
// Notes: pins move only just after a clock edge
`timescale 1ns/10ps
`default_nettype none
module host_pwm_model (
  input wire logic clk,
  input wire logic [3:0] level,
  output logic [3:0] pwm
);
  // pins start low, then follow the request
  initial pwm = 4'h0;
  always @(posedge clk) begin
    pwm <= level;
  end
endmodule // host_pwm_model
`default_nettype wire

// ### input_sync.sv
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are slow levels relative to CLK
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // two registering stages
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule // input_sync
`default_nettype wire
